/* src/isr_status_core.sv */
`default_nettype none
// Summary of operation
// - voltage-type range overload sets questionable bit 0
// - current range overload sets questionable bit 1
// - resistance range overload sets questionable bit 9
// - reading below lower limit sets questionable bit 11
// - reading above upper limit sets questionable bit 12
// - questionable summary is OR of events ANDed with mask
// - clear-status or event query clears questionable events
// - questionable mask cleared at power-on, preset, or write of zero
// - error queue holds 20 entries of 80 chars, oldest first
// - questionable mask loaded from written value, feeds summary
// - mask queries return weighted sum of set bits
// - clear-status zeroes status byte summary and all event registers
// - operation-complete command sets standard event bit 0
// - operation-complete query returns character 1
// - non-volatile flag set: power-up clears byte and event masks
// - power-on-clear flag query returns character 0 or 1
// - standard event mask loaded from value, feeds summary
// - status byte mask written and read back as value
// - status byte query equals serial poll but keeps bit 6
// - device clear aborts, idles trigger, flushes buffers, reopens input
// - device clear leaves status, error queue and configuration alone
// - serial interrupt character acts as device clear, then DTR true
// - standard event bits 0,2,3,4,5,7 used; bits 1 and 6 zero
// - serial poll clears only the request-service bit
// - standard event query clears the standard event register
module isr_status_core
  import isr_pkg::*;
(
  input  wire logic            clk,          // instrument clock
  input  wire logic            rst_b,        // power-on reset, active low
  input  wire isr_pkg::isr_cmd_t cmd,        // command code
  input  wire logic            cmdValid,     // command strobe, one cycle
  input  wire logic [15:0]     cmdValue,     // decimal value, as binary
  input  wire logic            pscNv,        // stored power-on-clear flag
  input  wire logic            voltOvld,     // voltage-type overload pulse
  input  wire logic            currOvld,     // current overload pulse
  input  wire logic            ohmsOvld,     // resistance overload pulse
  input  wire logic            limitLo,      // limit fail low pulse
  input  wire logic            limitHi,      // limit fail high pulse
  input  wire logic            queryErr,     // query error pulse
  input  wire logic            deviceErr,    // device error pulse
  input  wire logic            execErr,      // execution error pulse
  input  wire logic            cmdErr,       // command error pulse
  input  wire logic            msgAvail,     // output buffer holds a message
  input  wire logic            errPush,      // error entry push
  input  wire logic [isr_pkg::EQ_WIDTH-1:0] errText, // error entry text
  input  wire logic            errPop,       // error queue read
  input  wire logic            serialPoll,   // serial poll strobe
  input  wire logic            devClear,     // bus device clear strobe
  input  wire logic            serialBreak,  // serial interrupt character
  output logic [15:0]          respValue,    // numeric answer
  output logic [7:0]           respChar,     // character answer
  output logic                 respValid,    // answer strobe, one cycle
  output logic [7:0]           pollByte,     // serial poll answer
  output logic [isr_pkg::EQ_WIDTH-1:0] errOut, // oldest error entry
  output logic                 errEmpty,     // error queue empty
  output logic                 pscFlag,      // power-on-clear flag out
  output logic                 pscWrite,     // flag store strobe
  output logic                 abortMeas,    // abort measurement pulse
  output logic                 trigIdle,     // return trigger to idle
  output logic                 flushBufs,    // flush input/output buffers
  output logic                 cmdReady,     // ready for new command string
  output logic                 dtrLine,      // serial handshake line
  output logic                 srqOut        // service request
);
  import isr_pkg::*;

  typedef enum logic [1:0] {
    ISR_PWR  = 2'b00,
    ISR_RUN  = 2'b01,
    ISR_CLR  = 2'b11
  } isr_state_t;

  isr_state_t      state_q;
  logic [15:0]     quesEv_q;
  logic [15:0]     quesEn_q;
  logic [7:0]      stdEv_q;
  logic [7:0]      stdEn_q;
  logic [7:0]      sreEn_q;
  logic            rqs_q;
  logic            psc_q;
  logic [15:0]     respValue_q;
  logic [7:0]      respChar_q;
  logic            respValid_q;
  logic [7:0]      pollByte_q;
  logic [EQ_WIDTH-1:0] errOut_q;
  logic            errEmpty_q;
  logic            pscWrite_q;
  logic            abort_q;
  logic            trigIdle_q;
  logic            flush_q;
  logic            cmdReady_q;
  logic            dtr_q;
  logic            srq_q;
  logic [15:0]     quesSet;
  logic [7:0]      stdSet;
  logic            isCmd;
  logic            quesSum;
  logic            stdSum;
  logic [7:0]      stbNow;
  logic            anyClear;

  isr_errq_if eq ();

  // error queue untouched by device clear
  isr_err_queue u_errq (
    .clk   (clk),
    .rst_b (rst_b),
    .q     (eq.fifo)
  );

  assign eq.push     = errPush;
  assign eq.pushData = errText;
  assign eq.pop      = errPop;

  // commands are taken only while ready is shown, so the port and
  // the decode never disagree in the cycle after power-up or clear
  function automatic logic hit(input isr_cmd_t c);
    hit = cmdValid && (cmd == c) && cmdReady_q;
  endfunction

  assign isCmd    = cmdValid && cmdReady_q;
  assign anyClear = devClear || serialBreak;

  // questionable event sources, unused bits never set
  always_comb begin
    quesSet           = '0;
    quesSet[QB_VOLT]  = voltOvld;
    quesSet[QB_CURR]  = currOvld;
    quesSet[QB_OHMS]  = ohmsOvld;
    quesSet[QB_LIMLO] = limitLo;
    quesSet[QB_LIMHI] = limitHi;
    quesSet           = quesSet & QUES_USED;
  end

  // standard event sources
  always_comb begin
    stdSet            = '0;
    stdSet[SE_OPC]    = hit(ISR_OPC);
    stdSet[SE_QUERY]  = queryErr;
    stdSet[SE_DEVICE] = deviceErr;
    stdSet[SE_EXEC]   = execErr;
    stdSet[SE_CMD]    = cmdErr;
    stdSet[SE_PWR]    = (state_q == ISR_PWR);
    stdSet            = stdSet & SE_USED;
  end

  // summaries and live status byte
  assign quesSum = |(quesEv_q & quesEn_q);
  assign stdSum  = |(stdEv_q & stdEn_q);
  always_comb begin
    stbNow         = '0;
    stbNow[SB_QUES] = quesSum;
    stbNow[SB_MAV]  = msgAvail;
    stbNow[SB_ESB]  = stdSum;
    stbNow[SB_RQS]  = rqs_q;
  end

  // power-up sequencing and device clear phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ISR_PWR;
    end else begin
      unique case (state_q)
        ISR_PWR: state_q <= ISR_RUN;
        ISR_RUN: if (anyClear) state_q <= ISR_CLR;
        ISR_CLR: state_q <= ISR_RUN;
        default: state_q <= ISR_RUN;
      endcase
    end
  end

  // questionable event register, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quesEv_q <= '0;
    end else if (hit(ISR_CLS) || hit(ISR_QEV_RD)) begin
      quesEv_q <= quesSet;
    end else begin
      quesEv_q <= quesEv_q | quesSet;
    end
  end

  // questionable enable mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quesEn_q <= '0;
    end else if (state_q == ISR_PWR && !pscNv) begin
      quesEn_q <= '0;
    end else if (hit(ISR_PRESET)) begin
      quesEn_q <= '0;
    end else if (hit(ISR_QEN_WR)) begin
      quesEn_q <= cmdValue & QUES_USED;
    end
  end

  // standard event register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stdEv_q <= '0;
    end else if (hit(ISR_CLS) || hit(ISR_ESR_RD)) begin
      stdEv_q <= stdSet;
    end else begin
      stdEv_q <= stdEv_q | stdSet;
    end
  end

  // byte and event masks, cleared at power-up only under the flag;
  // no reset term, so a clear flag keeps them over power-up
  always_ff @(posedge clk) begin
    if (state_q == ISR_PWR) begin
      if (pscNv) begin
        stdEn_q <= '0;
        sreEn_q <= '0;
      end
    end else begin
      if (hit(ISR_ESE_WR)) stdEn_q <= cmdValue[7:0];
      if (hit(ISR_SRE_WR)) sreEn_q <= cmdValue[7:0] & SRE_USED;
    end
  end

  // request service latch, cleared by serial poll or clear-status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rqs_q <= 1'b0;
    end else if (|(stbNow & sreEn_q & ~8'h40) && !rqs_q) begin
      rqs_q <= 1'b1;
    end else if (serialPoll || hit(ISR_CLS)) begin
      rqs_q <= 1'b0;
    end
  end

  // power-on-clear flag mirror, loaded at release from storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psc_q      <= 1'b0;
      pscWrite_q <= 1'b0;
    end else begin
      pscWrite_q <= hit(ISR_PSC_WR);
      if (state_q == ISR_PWR) psc_q <= pscNv;
      else if (hit(ISR_PSC_WR)) psc_q <= cmdValue[0];
    end
  end

  // query answers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      respValue_q <= '0;
      respChar_q  <= '0;
      respValid_q <= 1'b0;
    end else begin
      respValid_q <= 1'b0;
      if (isCmd) begin
        unique case (cmd)
          ISR_QEN_RD: begin
            respValue_q <= quesEn_q;
            respValid_q <= 1'b1;
          end
          ISR_QEV_RD: begin
            respValue_q <= quesEv_q & QUES_USED;
            respValid_q <= 1'b1;
          end
          ISR_ESE_RD: begin
            respValue_q <= {8'h00, stdEn_q};
            respValid_q <= 1'b1;
          end
          ISR_ESR_RD: begin
            respValue_q <= {8'h00, stdEv_q};
            respValid_q <= 1'b1;
          end
          ISR_SRE_RD: begin
            respValue_q <= {8'h00, sreEn_q};
            respValid_q <= 1'b1;
          end
          ISR_STB_RD: begin
            respValue_q <= {8'h00, stbNow};
            respValid_q <= 1'b1;
          end
          ISR_OPC_Q: begin
            respChar_q  <= CHAR_ONE;
            respValid_q <= 1'b1;
          end
          ISR_PSC_RD: begin
            respChar_q  <= psc_q ? CHAR_ONE : CHAR_ZERO;
            respValid_q <= 1'b1;
          end
          default: begin
            respValid_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // serial poll image, error queue view, service request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pollByte_q <= '0;
      errOut_q   <= '0;
      errEmpty_q <= 1'b1;
      srq_q      <= 1'b0;
    end else begin
      pollByte_q <= stbNow;
      errOut_q   <= eq.popData;
      errEmpty_q <= eq.empty;
      srq_q      <= rqs_q;
    end
  end

  // device clear actions; status and masks untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_q    <= 1'b0;
      trigIdle_q <= 1'b0;
      flush_q    <= 1'b0;
      cmdReady_q <= 1'b0;
      dtr_q      <= 1'b0;
    end else begin
      abort_q    <= anyClear && state_q == ISR_RUN;
      trigIdle_q <= anyClear && state_q == ISR_RUN;
      flush_q    <= anyClear && state_q == ISR_RUN;
      if (state_q == ISR_RUN && !anyClear) cmdReady_q <= 1'b1;
      else cmdReady_q <= 1'b0;
      if (state_q == ISR_CLR) dtr_q <= 1'b1;
      else if (state_q == ISR_PWR) dtr_q <= 1'b1;
    end
  end

  assign respValue = respValue_q;
  assign respChar  = respChar_q;
  assign respValid = respValid_q;
  assign pollByte  = pollByte_q;
  assign errOut    = errOut_q;
  assign errEmpty  = errEmpty_q;
  assign pscFlag   = psc_q;
  assign pscWrite  = pscWrite_q;
  assign abortMeas = abort_q;
  assign trigIdle  = trigIdle_q;
  assign flushBufs = flush_q;
  assign cmdReady  = cmdReady_q;
  assign dtrLine   = dtr_q;
  assign srqOut    = srq_q;
endmodule
`default_nettype wire

/* src/isr_pkg.sv */
package isr_pkg;
  // questionable event bit positions
  localparam int QB_VOLT   = 0;
  localparam int QB_CURR   = 1;
  localparam int QB_OHMS   = 9;
  localparam int QB_LIMLO  = 11;
  localparam int QB_LIMHI  = 12;
  localparam logic [15:0] QUES_USED = 16'h1A03;
  // standard event bit positions
  localparam int SE_OPC    = 0;
  localparam int SE_QUERY  = 2;
  localparam int SE_DEVICE = 3;
  localparam int SE_EXEC   = 4;
  localparam int SE_CMD    = 5;
  localparam int SE_PWR    = 7;
  localparam logic [7:0] SE_USED = 8'hBD;
  // status byte bit positions
  localparam int SB_QUES   = 3;
  localparam int SB_MAV    = 4;
  localparam int SB_ESB    = 5;
  localparam int SB_RQS    = 6;
  localparam logic [7:0] SRE_USED = 8'hBF;
  // error queue shape
  localparam int EQ_DEPTH  = 20;
  localparam int EQ_CHARS  = 80;
  localparam int EQ_AW     = 5;
  localparam int EQ_WIDTH  = 8 * EQ_CHARS;
  // character codes
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE  = 8'h31;
  // host commands
  typedef enum logic [3:0] {
    ISR_NOP      = 4'h0,
    ISR_CLS      = 4'h1,
    ISR_ESE_WR   = 4'h2,
    ISR_ESE_RD   = 4'h3,
    ISR_ESR_RD   = 4'h4,
    ISR_OPC      = 4'h5,
    ISR_OPC_Q    = 4'h6,
    ISR_PSC_WR   = 4'h7,
    ISR_PSC_RD   = 4'h8,
    ISR_SRE_WR   = 4'h9,
    ISR_SRE_RD   = 4'hA,
    ISR_STB_RD   = 4'hB,
    ISR_QEN_WR   = 4'hC,
    ISR_QEN_RD   = 4'hD,
    ISR_QEV_RD   = 4'hE,
    ISR_PRESET   = 4'hF
  } isr_cmd_t;
endpackage

/* src/isr_errq_if.sv */
`default_nettype none
// push/pop path between the status core and its error queue
interface isr_errq_if;
  import isr_pkg::*;
  logic                push;
  logic [EQ_WIDTH-1:0] pushData;
  logic                pop;
  logic [EQ_WIDTH-1:0] popData;
  logic                empty;
  logic                full;
  modport core (output push, pushData, pop, input popData, empty, full);
  modport fifo (input push, pushData, pop, output popData, empty, full);
endinterface
`default_nettype wire

/* src/isr_err_queue.sv */
`default_nettype none
// first-in first-out error store, flip-flop based
module isr_err_queue
  import isr_pkg::*;
(
  input wire logic clk,   // instrument clock
  input wire logic rst_b, // async reset, active low
  isr_errq_if.fifo q      // push/pop port
);
  logic [EQ_WIDTH-1:0] mem [EQ_DEPTH];
  logic [EQ_AW-1:0]    wrPtr_q;
  logic [EQ_AW-1:0]    rdPtr_q;
  logic [EQ_AW:0]      count_q;
  logic                doPush;
  logic                doPop;

  // full entries refuse pushes; empty refuses pops
  assign doPush    = q.push && (count_q != (EQ_AW+1)'(EQ_DEPTH));
  assign doPop     = q.pop && (count_q != '0);
  assign q.empty   = (count_q == '0);
  assign q.full    = (count_q == (EQ_AW+1)'(EQ_DEPTH));
  assign q.popData = mem[rdPtr_q]; // oldest first

  function automatic logic [EQ_AW-1:0] bump(input logic [EQ_AW-1:0] p);
    bump = (p == EQ_AW'(EQ_DEPTH - 1)) ? '0 : p + EQ_AW'(1);
  endfunction

  // storage
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= q.pushData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) wrPtr_q <= bump(wrPtr_q);
      if (doPop)  rdPtr_q <= bump(rdPtr_q);
      count_q <= count_q + (EQ_AW+1)'(doPush) - (EQ_AW+1)'(doPop);
    end
  end
endmodule
`default_nettype wire

/* dv/isr_status_asserts.sv */
`default_nettype none
// port-level checks of the status core
module isr_status_asserts (
  input wire logic              clk,         // clock
  input wire logic              rst_b,       // reset
  input wire isr_pkg::isr_cmd_t cmd,         // command
  input wire logic              cmdValid,    // strobe
  input wire logic [15:0]       cmdValue,    // value
  input wire logic              cmdReady,    // accepting
  input wire logic              respValid,   // answer strobe
  input wire logic [15:0]       respValue,   // answer
  input wire logic [7:0]        respChar,    // char answer
  input wire logic              pscFlag,     // flag
  input wire logic              pscWrite,    // flag store
  input wire logic              abortMeas,   // abort
  input wire logic              trigIdle,    // trigger idle
  input wire logic              flushBufs,   // flush
  input wire logic              dtrLine,     // dtr
  input wire logic              srqOut,      // rqs
  input wire logic              devClear,    // clear
  input wire logic              serialBreak, // break char
  input wire logic              serialPoll   // poll
);
  import isr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // command taken
  logic tk;
  assign tk = cmdValid && cmdReady;
  AST_OPCQ_ONE: assert property (
    tk && cmd == ISR_OPC_Q |=> respValid && respChar == CHAR_ONE)
    else $error("opc query answer wrong");
  AST_QEV_SPARE: assert property (
    tk && cmd == ISR_QEV_RD |=> respValid && !(|(respValue & ~QUES_USED)))
    else $error("spare event bits set");
  AST_ESR_SPARE: assert property (
    tk && cmd == ISR_ESR_RD |=> respValid && respValue[1] == 1'b0
      && respValue[6] == 1'b0 && respValue[15:8] == 8'h00)
    else $error("spare std event bits set");
  AST_PSC_CHAR: assert property (
    tk && cmd == ISR_PSC_RD |=>
      respValid && respChar == (pscFlag ? CHAR_ONE : CHAR_ZERO))
    else $error("flag query answer wrong");
  AST_PSC_STORE: assert property (
    tk && cmd == ISR_PSC_WR |=> pscWrite ##1 pscFlag == $past(cmdValue[0], 2))
    else $error("flag not stored");
  AST_DCLR_SEQ: assert property (
    devClear && cmdReady |=> abortMeas && trigIdle && flushBufs
      && !cmdReady ##1 !cmdReady ##1 cmdReady)
    else $error("device clear sequence wrong");
  AST_BRK_DTR: assert property (
    serialBreak && cmdReady |=> abortMeas && dtrLine ##1 dtrLine [*3])
    else $error("break did not clear or raise dtr");
  AST_POLL_RQS: assert property (
    serialPoll && srqOut && !tk |=> ##1 !srqOut)
    else $error("poll left rqs set");
  AST_REFUSE: assert property (
    cmdValid && !cmdReady && !$past(tk) |=> !respValid)
    else $error("refused command answered");
endmodule
bind isr_status_core isr_status_asserts u_chk (.clk, .rst_b, .cmd,
  .cmdValid, .cmdValue, .cmdReady, .respValid, .respValue, .respChar,
  .pscFlag, .pscWrite, .abortMeas, .trigIdle, .flushBufs, .dtrLine,
  .srqOut, .devClear, .serialBreak, .serialPoll);
`default_nettype wire

/* dv/isr_host_model.sv */
`default_nettype none
// host side: sends one command, takes its answer
module isr_host_model (
  input  wire logic              clk,       // clock
  input  wire logic              cmdReady,  // device accepts
  input  wire logic              respValid, // answer strobe
  input  wire logic [15:0]       respValue, // numeric answer
  input  wire logic [7:0]        respChar,  // char answer
  output var isr_pkg::isr_cmd_t  cmd,       // command code
  output var logic               cmdValid,  // command strobe
  output var logic [15:0]        cmdValue   // written value
);
  import isr_pkg::*;
  // idle lines at time zero
  initial begin
    cmd = ISR_NOP;
    cmdValid = 1'b0;
    cmdValue = 16'h0000;
  end
  // wait ready, strobe one cycle, sample answer next cycle
  task automatic xfer(input isr_cmd_t c, input logic [15:0] w,
                      output logic [15:0] val, output logic [7:0] chr);
    int n;
    n = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd <= c;
    cmdValid <= 1'b1;
    cmdValue <= w;
    @(posedge clk);
    cmd <= ISR_NOP;
    cmdValid <= 1'b0;
    cmdValue <= ~w; // released: no stale value
    @(negedge clk);
    val = (respValid === 1'b1) ? respValue : 16'hFFFF;
    chr = (respValid === 1'b1) ? respChar : 8'hFF;
  endtask
  // strobe at once without waiting for ready, report any answer
  task automatic shove(input isr_cmd_t c, output logic got);
    @(posedge clk);
    cmd <= c;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmd <= ISR_NOP;
    cmdValid <= 1'b0;
    @(negedge clk);
    got = respValid;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
// self-checking bench of the status core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import isr_pkg::*;
  logic                clk, rst_b = 0, pscNv = 0, msgAvail = 0;
  logic                errPush = 0, errPop = 0, serialPoll = 0;
  logic                devClear = 0, serialBreak = 0, cmdValid;
  logic [4:0]          qEvt = 0;
  logic [3:0]          sEvt = 0;
  isr_cmd_t            cmd;
  logic [15:0]         cmdValue, respValue, v;
  logic [7:0]          respChar, pollByte, ch;
  logic [EQ_WIDTH-1:0] errText = 0, errOut;
  logic                respValid, errEmpty, pscFlag, pscWrite, abortMeas;
  logic                trigIdle, flushBufs, cmdReady, dtrLine, srqOut;
  int                  err_total = 0, samples_checked = 0, cyc = 0;
  isr_status_core uut (.clk, .rst_b, .cmd, .cmdValid, .cmdValue, .pscNv,
    .voltOvld(qEvt[0]), .currOvld(qEvt[1]), .ohmsOvld(qEvt[2]),
    .limitLo(qEvt[3]), .limitHi(qEvt[4]), .queryErr(sEvt[0]),
    .deviceErr(sEvt[1]), .execErr(sEvt[2]), .cmdErr(sEvt[3]),
    .msgAvail, .errPush, .errText, .errPop, .serialPoll, .devClear,
    .serialBreak, .respValue, .respChar, .respValid, .pollByte,
    .errOut, .errEmpty, .pscFlag, .pscWrite, .abortMeas, .trigIdle,
    .flushBufs, .cmdReady, .dtrLine, .srqOut);
  isr_host_model host (.clk, .cmdReady, .respValid, .respValue,
    .respChar, .cmd, .cmdValid, .cmdValue);
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkE(input logic [EQ_WIDTH-1:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmdDo(input isr_cmd_t c, input logic [15:0] w);
    host.xfer(c, w, v, ch);
  endtask
  // power cycle with a given stored flag
  task automatic pwr(input logic nv);
    @(posedge clk);
    pscNv <= nv;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // one-cycle event pulses
  task automatic pulse(input logic [4:0] q, input logic [3:0] s);
    @(posedge clk);
    qEvt <= q;
    sEvt <= s;
    @(posedge clk);
    qEvt <= 5'h00;
    sEvt <= 4'h0;
  endtask
  task automatic t_power;
    cmdDo(ISR_ESR_RD, 0);
    chk(v, 16'h0080);
    cmdDo(ISR_ESR_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_QEN_RD, 0);
    chk(v, 16'h0000);
    $display("power test done");
  endtask
  task automatic t_ques;
    logic [15:0] w [5] = '{16'h0001, 16'h0002, 16'h0200, 16'h0800,
                           16'h1000};
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i, 4'h0);
      cmdDo(ISR_QEV_RD, 0);
      chk(v, w[i]);
    end
    cmdDo(ISR_QEV_RD, 0);
    chk(v, 16'h0000);
    pulse(5'h1F, 4'h0);
    cmdDo(ISR_CLS, 0);
    cmdDo(ISR_QEV_RD, 0);
    chk(v, 16'h0000);
    $display("event test done");
  endtask
  task automatic t_mask;
    cmdDo(ISR_QEN_WR, 16'h0800);
    cmdDo(ISR_QEN_RD, 0);
    chk(v, 16'h0800);
    pulse(5'h10, 4'h0);
    cmdDo(ISR_STB_RD, 0);
    chk(v & 16'h0008, 16'h0000);
    pulse(5'h08, 4'h0);
    cmdDo(ISR_STB_RD, 0);
    chk(v & 16'h0008, 16'h0008);
    cmdDo(ISR_PRESET, 0);
    cmdDo(ISR_QEN_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_QEN_WR, 16'h1A03);
    cmdDo(ISR_QEN_WR, 16'h0000);
    cmdDo(ISR_QEN_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_CLS, 0);
    $display("mask test done");
  endtask
  task automatic t_std;
    cmdDo(ISR_ESE_WR, 16'h0001);
    cmdDo(ISR_ESE_RD, 0);
    chk(v, 16'h0001);
    cmdDo(ISR_OPC, 0);
    cmdDo(ISR_ESR_RD, 0);
    chk(v, 16'h0001);
    pulse(5'h00, 4'hF);
    cmdDo(ISR_ESR_RD, 0);
    chk(v, 16'h003C);
    cmdDo(ISR_SRE_WR, 16'h0020);
    cmdDo(ISR_SRE_RD, 0);
    chk(v, 16'h0020);
    msgAvail <= 1'b1;
    cmdDo(ISR_OPC, 0);
    repeat (2) begin
      cmdDo(ISR_STB_RD, 0);
      chk(v, 16'h0070);
    end
    @(posedge clk);
    serialPoll <= 1'b1;
    @(posedge clk);
    serialPoll <= 1'b0;
    repeat (2) @(negedge clk);
    chk({8'h00, pollByte}, 16'h0030);
    cmdDo(ISR_CLS, 0);
    cmdDo(ISR_STB_RD, 0);
    chk(v, 16'h0010);
    msgAvail <= 1'b0;
    $display("standard test done");
  endtask
  task automatic t_psc;
    cmdDo(ISR_ESE_WR, 16'h003C);
    cmdDo(ISR_SRE_WR, 16'h0020);
    cmdDo(ISR_PSC_WR, 16'h0001);
    cmdDo(ISR_PSC_RD, 0);
    chk({8'h00, ch}, {8'h00, CHAR_ONE});
    pwr(1'b1);
    cmdDo(ISR_ESE_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_SRE_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_ESE_WR, 16'h003C);
    cmdDo(ISR_QEN_WR, 16'h0001);
    pwr(1'b0);
    cmdDo(ISR_ESE_RD, 0);
    chk(v, 16'h003C);
    cmdDo(ISR_QEN_RD, 0);
    chk(v, 16'h0000);
    cmdDo(ISR_PSC_RD, 0);
    chk({8'h00, ch}, {8'h00, CHAR_ZERO});
    $display("flag test done");
  endtask
  task automatic t_err;
    logic got;
    for (int i = 0; i < 21; i++) begin
      @(posedge clk);
      errPush <= 1'b1;
      errText <= {EQ_CHARS{8'h41 + 8'(i)}};
    end
    @(posedge clk);
    errPush <= 1'b0;
    devClear <= 1'b1;
    @(posedge clk);
    devClear <= 1'b0;
    host.shove(ISR_OPC_Q, got);
    chk({15'h0000, got}, 16'h0000);
    repeat (4) @(posedge clk);
    serialBreak <= 1'b1;
    @(posedge clk);
    serialBreak <= 1'b0;
    repeat (4) @(negedge clk);
    chk({15'h0000, dtrLine}, 16'h0001);
    cmdDo(ISR_ESE_RD, 0);
    chk(v, 16'h003C);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      chkE(errOut, {EQ_CHARS{8'h41 + 8'(i)}});
      @(posedge clk);
      errPop <= 1'b1;
      @(posedge clk);
      errPop <= 1'b0;
      @(posedge clk);
    end
    @(negedge clk);
    chk({15'h0000, errEmpty}, 16'h0001);
    $display("queue test done");
  endtask
  // main sequence
  initial begin
    pwr(1'b1);
    t_power();
    t_ques();
    t_mask();
    t_std();
    t_psc();
    t_err();
    test_done();
  end
endmodule
`default_nettype wire
